// ==== verilog/tfef_pkg.sv ====
// Constants, register map and types of the trigger, frame and embedded-row formatter.
package tfef_pkg;
  // Marker and tag words of the inserted rows.
  localparam logic [11:0] TAG_DUMP = 12'h0a0;
  localparam logic [11:0] MK_AHI   = 12'haa0;
  localparam logic [11:0] MK_ALO   = 12'ha50;
  localparam logic [11:0] MK_VAL   = 12'h5a0;
  localparam logic [11:0] TAG_STAT = 12'h0b0;
  // Register ranges dumped into the two data rows.
  localparam logic [15:0] DUMP1_FIRST  = 16'h3000;
  localparam logic [15:0] DUMP1_LAST   = 16'h312f;
  localparam logic [15:0] DUMP2A_FIRST = 16'h3136;
  localparam logic [15:0] DUMP2A_LAST  = 16'h31bf;
  localparam logic [15:0] DUMP2B_FIRST = 16'h31d0;
  localparam logic [15:0] DUMP2B_LAST  = 16'h31ff;
  localparam int DUMP1_REGS  = (DUMP1_LAST - DUMP1_FIRST + 1) / 2;
  localparam int DUMP2A_REGS = (DUMP2A_LAST - DUMP2A_FIRST + 1) / 2;
  localparam int DUMP2B_REGS = (DUMP2B_LAST - DUMP2B_FIRST + 1) / 2;
  localparam int DUMP_HDR    = 5;
  localparam int DUMP1_WORDS = DUMP_HDR + 4 * DUMP1_REGS;
  localparam int DUMP2_WORDS = DUMP_HDR + 4 * (DUMP2A_REGS + DUMP2B_REGS);
  // Statistics layout.
  localparam int HIST_BINS    = 244;
  localparam int HIST_BINS_12 = 64;
  localparam int STAT1_HDR    = 3;
  localparam int STAT1_WORDS  = STAT1_HDR + HIST_BINS;
  localparam int STAT2_WORDS  = 7;
  localparam int EMB_ROWS     = 2;
  // Sensor-style register addresses; the bus word index is (address - base) / 2.
  localparam logic [15:0] SADDR_BASE   = 16'h3000;
  localparam logic [15:0] SADDR_INTEG  = 16'h3012;
  localparam logic [15:0] SADDR_CTRL   = 16'h301a;
  localparam logic [15:0] SADDR_MODE   = 16'h3028;
  localparam logic [15:0] SADDR_STATUS = 16'h3030;
  localparam logic [15:0] SADDR_FCOUNT = 16'h303a;
  localparam logic [15:0] SADDR_FID    = 16'h31d2;
  // Field positions and reset values.
  localparam int CTRL_STREAM_BIT = 2;
  localparam int MODE_SINGLE_BIT = 0;
  localparam int MODE_EMBED_BIT  = 1;
  localparam logic [15:0] CTRL_RST  = 16'h0000;
  localparam logic [15:0] MODE_RST  = 16'h0000;
  localparam logic [15:0] INTEG_RST = 16'h0010;
  localparam logic [15:0] FID_RST   = 16'h0000;
  // Consecutive high samples needed to qualify the trigger.
  localparam logic [1:0] TRIG_QUAL_CYCLES = 2'h3;
  // Sequencer states.
  typedef enum logic [1:0] {
    ST_STOP   = 2'b00,
    ST_FRAME  = 2'b01,
    ST_VBLANK = 2'b10
  } tfef_state_type;
  // Kind of the output row at the read pointer.
  typedef enum logic [2:0] {
    RK_NONE  = 3'b000,
    RK_DUMP1 = 3'b001,
    RK_DUMP2 = 3'b010,
    RK_IMAGE = 3'b011,
    RK_STAT1 = 3'b100,
    RK_STAT2 = 3'b101
  } tfef_row_type;
endpackage

// ==== verilog/tfef_top.sv ====
// Frame sequencer with trigger qualification, flash strobe and embedded data and statistics rows.
`timescale 1ns/10ps
module tfef_top
  import tfef_pkg::*;
#(
  parameter int ACT_W    = 640,
  parameter int ACT_H    = 480,
  parameter int LINE_PCK = 1024,
  parameter int VB_LINES = 26
) (
  // Clock and reset.
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  // Avalon-MM register slave.
  input  wire logic [7:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  // Trigger pin and pixel array.
  input  wire logic        trigger_i,
  input  wire logic [11:0] array_pixel_i,
  // Row pointers towards the array.
  output logic      [15:0] shutter_row_o,
  output logic             shutter_strobe_o,
  output logic      [15:0] read_row_o,
  output logic             read_strobe_o,
  // Parallel pixel output and flash.
  output logic             pixel_clock_out_o,
  output logic      [11:0] pixel_data_o,
  output logic             frame_valid_o,
  output logic             line_valid_o,
  output logic             flash_o
);

  tfef_state_type state;
  tfef_row_type   kind;
  logic        ph, tick, ack, trig_meta, trig_sync, trig_ok, start_req, line_end;
  logic        frame_emb, in_out, frame_valid_c;
  logic [1:0]  trig_cnt;
  logic [15:0] ctrl, mode, integ, fid, fcount, frame_int, fl, col, vb;
  logic [15:0] pre, o_row, img_row, out_rows, row_words, frame_last;
  logic [15:0] j, n, first_addr, reg_addr, reg_val, saddr;
  logic [11:0] next_word, pmin, pmax, mean;
  logic [31:0] sum;
  logic [9:0]  hist [HIST_BINS_12];

  // Register contents seen both by the bus and by the dump rows.
  function automatic logic [15:0] reg_at(input logic [15:0] a);
    case (a)
      SADDR_INTEG:  reg_at = integ;
      SADDR_CTRL:   reg_at = ctrl;
      SADDR_MODE:   reg_at = mode;
      SADDR_STATUS: reg_at = {11'h000, state, trig_ok, flash_o, frame_valid_o};
      SADDR_FCOUNT: reg_at = fcount;
      SADDR_FID:    reg_at = fid;
      default:      reg_at = 16'h0000;
    endcase
  endfunction

  // Pixel rate is half the system clock; the receiver samples on the rising pixel clock.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ph <= 1'b0;
    end else begin
      ph <= ~ph;
    end
  end
  assign tick = ph;
  assign pixel_clock_out_o = ph;

  // Two-flop synchroniser on the trigger pin.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      trig_meta <= 1'b0;
      trig_sync <= 1'b0;
    end else begin
      trig_meta <= trigger_i;
      trig_sync <= trig_meta;
    end
  end

  // Level qualifier, reset by every low sample and held clear during frame valid.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      trig_cnt <= 2'h0;
    end else if (frame_valid_c || !trig_sync) begin
      trig_cnt <= 2'h0;
    end else if (trig_cnt != TRIG_QUAL_CYCLES) begin
      trig_cnt <= trig_cnt + 2'h1;
    end
  end
  assign trig_ok = (trig_cnt == TRIG_QUAL_CYCLES);

  // Video runs on the stream bit or a held trigger; single frame needs the trigger.
  assign start_req = trig_ok | (ctrl[CTRL_STREAM_BIT] & ~mode[MODE_SINGLE_BIT]);

  // Row decode at the current frame line.
  always_comb begin
    pre        = frame_emb ? 16'(EMB_ROWS) : 16'h0000;
    out_rows   = 16'(ACT_H) + pre + pre;
    frame_last = frame_int + out_rows - 16'h0001;
    in_out     = (state == ST_FRAME) && (fl >= frame_int);
    o_row      = fl - frame_int;
    img_row    = o_row - pre;
    kind       = RK_NONE;
    if (in_out) begin
      if (o_row < pre) begin
        kind = (o_row == 16'h0000) ? RK_DUMP1 : RK_DUMP2;
      end else if (img_row < 16'(ACT_H)) begin
        kind = RK_IMAGE;
      end else begin
        kind = (img_row == 16'(ACT_H)) ? RK_STAT1 : RK_STAT2;
      end
    end
    case (kind)
      RK_DUMP1: row_words = 16'(DUMP1_WORDS);
      RK_DUMP2: row_words = 16'(DUMP2_WORDS);
      RK_IMAGE: row_words = 16'(ACT_W);
      RK_STAT1: row_words = 16'(STAT1_WORDS);
      RK_STAT2: row_words = 16'(STAT2_WORDS);
      default:  row_words = 16'h0000;
    endcase
  end
  // Frame valid covers inserted rows as well as the image.
  assign frame_valid_c = in_out;
  assign line_end      = tick && (col == 16'(LINE_PCK - 1));

  // Dump row addressing: five header words, then four words per register.
  always_comb begin
    j          = col - 16'(DUMP_HDR);
    n          = {2'b00, j[15:2]};
    first_addr = (kind == RK_DUMP1) ? DUMP1_FIRST : DUMP2A_FIRST;
    if (kind == RK_DUMP1) begin
      reg_addr = DUMP1_FIRST + {n[14:0], 1'b0};
    end else if (n < 16'(DUMP2A_REGS)) begin
      reg_addr = DUMP2A_FIRST + {n[14:0], 1'b0};
    end else begin
      reg_addr = DUMP2B_FIRST + {n[14:0] - 15'(DUMP2A_REGS), 1'b0};
    end
    reg_val = reg_at(reg_addr);
  end

  // Mean by constant division; pmin and pmax are the extreme codes seen.
  assign mean = 12'(sum / 32'(ACT_W * ACT_H));

  // Word selection for the next pixel slot.
  always_comb begin
    next_word = 12'h000;
    case (kind)
      RK_DUMP1, RK_DUMP2: begin
        if (col == 16'h0000) begin
          next_word = TAG_DUMP;
        end else if (col == 16'h0001) begin
          next_word = MK_AHI;
        end else if (col == 16'h0002) begin
          next_word = {first_addr[15:8], 4'h0};
        end else if (col == 16'h0003) begin
          next_word = MK_ALO;
        end else if (col == 16'h0004) begin
          next_word = {first_addr[7:0], 4'h0};
        end else if (!j[0]) begin
          next_word = MK_VAL;
        end else begin
          next_word = j[1] ? {reg_val[7:0], 4'h0} : {reg_val[15:8], 4'h0};
        end
      end
      RK_IMAGE: begin
        next_word = array_pixel_i;
      end
      RK_STAT1: begin
        if (col == 16'h0000) begin
          next_word = TAG_STAT;
        end else if (col == 16'h0001) begin
          next_word = {fcount[9:0], 2'b00};
        end else if (col == 16'h0002) begin
          next_word = {fid[9:0], 2'b00};
        end else if (col < 16'(STAT1_HDR + HIST_BINS_12)) begin
          next_word = {hist[6'(col - 16'(STAT1_HDR))], 2'b00};
        end
        // Bins above the 12-bit range stay zero: pixel codes never reach them.
      end
      RK_STAT2: begin
        case (col)
          16'h0000: next_word = TAG_STAT;
          16'h0001: next_word = {mean[11:2], 2'b00};
          16'h0002: next_word = {pmin[11:2], 2'b00};
          16'h0003: next_word = {pmax[11:2], 2'b00};
          default:  next_word = 12'h000;
        endcase
      end
      default: next_word = 12'h000;
    endcase
  end

  // Sequencer: stop, frame lines, then vertical blanking with a trigger decision.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state     <= ST_STOP;
      fl        <= 16'h0000;
      col       <= 16'h0000;
      vb        <= 16'h0000;
      frame_emb <= 1'b0;
      frame_int <= INTEG_RST;
      fcount    <= 16'h0000;
    end else if (tick) begin
      col <= line_end ? 16'h0000 : col + 16'h0001;
      case (state)
        ST_STOP: begin
          col <= 16'h0000;
          if (start_req) begin
            state     <= ST_FRAME;
            fl        <= 16'h0000;
            frame_emb <= mode[MODE_EMBED_BIT];
            frame_int <= (integ == 16'h0000) ? 16'h0001 : integ;
          end
        end
        ST_FRAME: begin
          if (line_end) begin
            fl <= fl + 16'h0001;
            if (fl == frame_last) begin
              state  <= ST_VBLANK;
              vb     <= 16'h0000;
              fcount <= fcount + 16'h0001;
            end
          end
        end
        ST_VBLANK: begin
          if (line_end) begin
            vb <= vb + 16'h0001;
            if (vb == 16'(VB_LINES - 1)) begin
              fl        <= 16'h0000;
              frame_emb <= mode[MODE_EMBED_BIT];
              frame_int <= (integ == 16'h0000) ? 16'h0001 : integ;
              state     <= start_req ? ST_FRAME : ST_STOP;
            end
          end
        end
        default: state <= ST_STOP;
      endcase
    end
  end

  // Output stage and row pointers, all registered on the pixel slot.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pixel_data_o     <= 12'h000;
      frame_valid_o    <= 1'b0;
      line_valid_o     <= 1'b0;
      flash_o          <= 1'b0;
      shutter_row_o    <= 16'h0000;
      shutter_strobe_o <= 1'b0;
      read_row_o       <= 16'h0000;
      read_strobe_o    <= 1'b0;
    end else begin
      shutter_strobe_o <= 1'b0;
      read_strobe_o    <= 1'b0;
      if (tick) begin
        frame_valid_o <= frame_valid_c;
        line_valid_o  <= frame_valid_c && (col < row_words);
        pixel_data_o  <= (col < row_words) ? next_word : 12'h000;
        // Exposure runs from the first row release to the last row sample.
        flash_o <= (state == ST_FRAME) && (fl >= pre) && (fl < frame_int + pre + 16'(ACT_H));
        if ((state == ST_FRAME) && (col == 16'h0000) && (fl >= pre) && (fl < pre + 16'(ACT_H))) begin
          shutter_row_o    <= fl - pre;
          shutter_strobe_o <= 1'b1;
        end
        if ((kind == RK_IMAGE) && (col == 16'h0000)) begin
          read_row_o    <= img_row;
          read_strobe_o <= 1'b1;
        end
      end
    end
  end

  // Histogram, sum and extremes over the image rows of the current frame.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < HIST_BINS_12; i++) begin
        hist[i] <= 10'h000;
      end
      sum  <= 32'h0000_0000;
      pmin <= 12'hfff;
      pmax <= 12'h000;
    end else if (tick && (state != ST_FRAME)) begin
      for (int i = 0; i < HIST_BINS_12; i++) begin
        hist[i] <= 10'h000;
      end
      sum  <= 32'h0000_0000;
      pmin <= 12'hfff;
      pmax <= 12'h000;
    end else if (tick && (kind == RK_IMAGE) && (col < 16'(ACT_W))) begin
      if (hist[array_pixel_i[11:6]] != 10'h3ff) begin
        hist[array_pixel_i[11:6]] <= hist[array_pixel_i[11:6]] + 10'h001;
      end
      sum <= sum + {20'h00000, array_pixel_i};
      if (array_pixel_i < pmin) begin
        pmin <= array_pixel_i;
      end
      if (array_pixel_i > pmax) begin
        pmax <= array_pixel_i;
      end
    end
  end

  // Avalon slave: one wait cycle, writes land on the edge that samples waitrequest low, one after the wait ends.
  assign saddr             = SADDR_BASE + {7'h00, avs_address_i, 1'b0};
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack;
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack            <= 1'b0;
      avs_readdata_o <= 32'h0000_0000;
    end else begin
      ack <= (avs_read_i | avs_write_i) & ~ack;
      if (avs_read_i && !ack) begin
        avs_readdata_o <= {16'h0000, reg_at(saddr)};
      end
    end
  end

  // Writable registers; byte enables select the two low lanes.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl  <= CTRL_RST;
      mode  <= MODE_RST;
      integ <= INTEG_RST;
      fid   <= FID_RST;
    end else if (avs_write_i && ack) begin
      case (saddr)
        SADDR_CTRL: begin
          if (avs_byteenable_i[0]) ctrl[7:0] <= avs_writedata_i[7:0];
          if (avs_byteenable_i[1]) ctrl[15:8] <= avs_writedata_i[15:8];
        end
        SADDR_MODE: begin
          if (avs_byteenable_i[0]) mode[7:0] <= avs_writedata_i[7:0];
          if (avs_byteenable_i[1]) mode[15:8] <= avs_writedata_i[15:8];
        end
        SADDR_INTEG: begin
          if (avs_byteenable_i[0]) integ[7:0] <= avs_writedata_i[7:0];
          if (avs_byteenable_i[1]) integ[15:8] <= avs_writedata_i[15:8];
        end
        SADDR_FID: begin
          if (avs_byteenable_i[0]) fid[7:0] <= avs_writedata_i[7:0];
          if (avs_byteenable_i[1]) fid[15:8] <= avs_writedata_i[15:8];
        end
        default: ctrl <= ctrl;
      endcase
    end
  end

endmodule

// ==== verification/tfef_checker.sv ====
// Concurrent checks on the ports of the formatter top.
`timescale 1ns/10ps
module tfef_checker (
  // Clock and reset.
  input wire logic        clk_sys_i,
  input wire logic        rst_n_i,
  // Observed outputs.
  input wire logic        shutter_strobe_o,
  input wire logic        read_strobe_o,
  input wire logic        pixel_clock_out_o,
  input wire logic [11:0] pixel_data_o,
  input wire logic        frame_valid_o,
  input wire logic        line_valid_o,
  input wire logic        flash_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  // Every inserted or image row must sit inside the frame.
  a_line_in_frame: assert property (line_valid_o |-> frame_valid_o)
    else $error("line valid seen outside frame valid");
  // Words may only move when the output clock falls, so a receiver sees them settled.
  a_word_stable: assert property (!$fell(pixel_clock_out_o) |-> $stable(pixel_data_o))
    else $error("pixel word changed off the output clock fall");
  // The first edge after reset still sees the reset value twice, so it is skipped.
  a_pclk_toggle: assert property ($past(rst_n_i) |-> pixel_clock_out_o != $past(pixel_clock_out_o))
    else $error("output clock missed a toggle");
  // Integration opens with the release of the first row; dump rows may come out before it.
  a_flash_start: assert property ($rose(flash_o) |-> shutter_strobe_o)
    else $error("flash rose without a row release");
  // Each frame opens with a framed row, so no empty line leads the output.
  a_frame_opens_row: assert property ($rose(frame_valid_o) |-> line_valid_o)
    else $error("frame valid rose without line valid");
  a_shutter_pulse: assert property (shutter_strobe_o |=> !shutter_strobe_o)
    else $error("shutter strobe longer than one cycle");
  a_read_pulse: assert property (read_strobe_o |=> !read_strobe_o)
    else $error("read strobe longer than one cycle");
  a_read_in_flash: assert property (read_strobe_o |-> flash_o)
    else $error("row read outside the integration span");
  a_shut_in_flash: assert property (shutter_strobe_o |-> ##[0:1] flash_o)
    else $error("row released while flash low");
endmodule

bind tfef_top tfef_checker u_chk (
  .clk_sys_i        (clk_sys_i),
  .rst_n_i          (rst_n_i),
  .shutter_strobe_o (shutter_strobe_o),
  .read_strobe_o    (read_strobe_o),
  .pixel_clock_out_o(pixel_clock_out_o),
  .pixel_data_o     (pixel_data_o),
  .frame_valid_o    (frame_valid_o),
  .line_valid_o     (line_valid_o),
  .flash_o          (flash_o)
);

// ==== verification/tfef_rx_model.sv ====
// Downstream receiver model: collects the line-framed words of the pixel output.
`timescale 1ns/10ps
module tfef_rx_model (
  // Parallel pixel stream from the formatter.
  input wire logic        pixel_clock_out_i,
  input wire logic [11:0] pixel_data_i,
  input wire logic        line_valid_i
);
  logic [11:0] words[$];
  int          lens[$];
  int          cnt = 0;
  // Words are taken on the rising output clock, half a slot after they change.
  always @(posedge pixel_clock_out_i) begin
    if (line_valid_i) begin
      words.push_back(pixel_data_i);
      cnt++;
    end else if (cnt > 0) begin
      lens.push_back(cnt);
      cnt = 0;
    end
  end
endmodule

// ==== verification/tfef_top_tb.sv ====
// Self-checking bench: registers, trigger qualification and embedded row layout.
`timescale 1ns/10ps
module tfef_top_tb;
  import tfef_pkg::*;
  localparam int AW = 8;
  localparam int AH = 4;
  // Image starts after both dump rows; statistics follow the image.
  localparam int S1 = 990 + AW * AH;
  logic        clk_sys_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic [7:0]  avs_address_i = 8'h00;
  logic        avs_read_i = 1'b0;
  logic        avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic        trigger_i = 1'b0;
  logic [11:0] array_pixel_i = 12'h000;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o, shutter_strobe_o, read_strobe_o;
  logic [15:0] shutter_row_o, read_row_o, q, fid;
  logic        pixel_clock_out_o, frame_valid_o, line_valid_o, flash_o;
  logic [11:0] pixel_data_o;
  int          num_errors = 0;
  int          checked = 0;
  int          seed = 68;
  int          hi;
  int          sh_k = 0;
  int          rd_k = 0;
  logic [7:0]  ri [6] = '{8'h09, 8'h0d, 8'h14, 8'he9, 8'h1d, 8'h03};
  logic [15:0] re [6] = '{INTEG_RST, CTRL_RST, MODE_RST, FID_RST, 16'h0000, 16'h0000};
  tfef_top #(.ACT_W(AW), .ACT_H(AH), .LINE_PCK(640), .VB_LINES(2)) u_tfef_top (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(4'h3), .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .trigger_i(trigger_i), .array_pixel_i(array_pixel_i), .shutter_row_o(shutter_row_o),
    .shutter_strobe_o(shutter_strobe_o), .read_row_o(read_row_o), .read_strobe_o(read_strobe_o),
    .pixel_clock_out_o(pixel_clock_out_o), .pixel_data_o(pixel_data_o),
    .frame_valid_o(frame_valid_o), .line_valid_o(line_valid_o), .flash_o(flash_o));
  tfef_rx_model u_tfef_rx_model (.pixel_clock_out_i(pixel_clock_out_o), .pixel_data_i(pixel_data_o),
    .line_valid_i(line_valid_o));
  // System clock of 40 MHz.
  always #12.5 clk_sys_i = ~clk_sys_i;
  // Row pointers walk 0 to AH-1 in every frame, and each row is released before it is sampled.
  always @(posedge clk_sys_i) begin
    if (shutter_strobe_o === 1'b1) begin
      chk("shutter row", 16'(sh_k % AH), shutter_row_o);
      sh_k++;
    end
    if (read_strobe_o === 1'b1) begin
      chk("read row", 16'(rd_k % AH), read_row_o);
      chk("row released before read", 16'h0001, {15'h0, sh_k > rd_k});
      rd_k++;
    end
  end
  // Random image content keeps the pixel path busy.
  always @(posedge clk_sys_i) array_pixel_i <= 12'($random(seed));
  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_w(input int off, input logic [11:0] e);
    chk($sformatf("row word %0d", off), {4'h0, e}, {4'h0, u_tfef_rx_model.words[off]});
  endtask
  // One Avalon transfer, held until waitrequest is sampled low at a rising edge.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [15:0] d);
    int n;
    n = 0;
    avs_address_i <= a;
    avs_writedata_i <= {16'h0000, d};
    avs_write_i <= wr;
    avs_read_i <= !wr;
    @(posedge clk_sys_i);
    while (avs_waitrequest_o !== 1'b0 && n < 20) begin
      @(posedge clk_sys_i);
      n++;
    end
    if (avs_waitrequest_o !== 1'b0) num_errors++;
    q = avs_readdata_o[15:0];
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask
  task automatic wait_fv(input logic lvl);
    int n;
    n = 0;
    while (frame_valid_o !== lvl && n < 40000) begin
      @(posedge clk_sys_i);
      n++;
    end
    chk("frame valid level", {15'h0, lvl}, {15'h0, frame_valid_o});
  endtask
  // Row lengths and the fixed words of every inserted row of one frame.
  task automatic chk_frame(input logic [15:0] f);
    int lens [8] = '{DUMP1_WORDS, DUMP2_WORDS, AW, AW, AW, AW, STAT1_WORDS, STAT2_WORDS};
    int sm = 0;
    int mn = 4095;
    int mx = 0;
    int hb [64] = '{default: 0};
    logic [11:0] px;
    chk("row count", 16'd8, 16'(u_tfef_rx_model.lens.size()));
    foreach (lens[i]) chk("row length", 16'(lens[i]), 16'(u_tfef_rx_model.lens[i]));
    chk_w(0, 12'h0a0);
    chk_w(1, 12'haa0);
    chk_w(2, 12'h300);
    chk_w(3, 12'ha50);
    chk_w(4, 12'h000);
    for (int i = 5; i < 9; i++) chk_w(i, i[0] ? 12'h5a0 : 12'h000);
    for (int i = 41; i < 45; i++) chk_w(i, i[0] ? 12'h5a0 : (i == 44 ? 12'h010 : 12'h000));
    chk_w(613, 12'h0a0);
    chk_w(615, 12'h310);
    chk_w(617, 12'h360);
    chk_w(899, {fid[15:8], 4'h0});
    chk_w(901, {fid[7:0], 4'h0});
    chk_w(S1, 12'h0b0);
    chk_w(S1 + 1, {f[9:0], 2'b00});
    chk_w(S1 + 2, {fid[9:0], 2'b00});
    chk_w(S1 + 247, 12'h0b0);
    // Reference statistics from the image words the receiver collected.
    for (int k = 0; k < AW * AH; k++) begin
      px = u_tfef_rx_model.words[990 + k];
      sm += px;
      if (px < mn) mn = px;
      if (px > mx) mx = px;
      hb[px[11:6]]++;
    end
    for (int b = 0; b < 64; b++) chk_w(S1 + 3 + b, {hb[b][9:0], 2'b00});
    chk_w(S1 + 67, 12'h000);
    px = 12'(sm / (AW * AH));
    chk_w(S1 + 248, {px[11:2], 2'b00});
    px = 12'(mn);
    chk_w(S1 + 249, {px[11:2], 2'b00});
    px = 12'(mx);
    chk_w(S1 + 250, {px[11:2], 2'b00});
    u_tfef_rx_model.words.delete();
    u_tfef_rx_model.lens.delete();
  endtask
  // Watchdog sized well above four short frames and the idle checks.
  initial begin
    #(25 * 90000);
    num_errors++;
    close_out();
  end
  initial begin
    repeat (10) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    @(posedge clk_sys_i);
    foreach (ri[i]) begin
      bus(1'b0, ri[i], 16'h0000);
      chk("reset value", re[i], q);
    end
    bus(1'b1, 8'h03, 16'hffff);
    bus(1'b0, 8'h03, 16'h0000);
    chk("unmapped read", 16'h0000, q);
    fid = 16'($random(seed));
    bus(1'b1, 8'he9, fid);
    bus(1'b1, 8'h09, 16'h0001);
    bus(1'b1, 8'h14, 16'h0003);
    bus(1'b0, 8'he9, 16'h0000);
    chk("frame id", fid, q);
    // Two high samples must not qualify the trigger.
    trigger_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    trigger_i <= 1'b0;
    repeat (40) @(posedge clk_sys_i);
    chk("flash after short trigger", 16'h0000, {15'h0, flash_o});
    trigger_i <= 1'b1;
    wait_fv(1'b1);
    wait_fv(1'b0);
    repeat (8) @(posedge clk_sys_i);
    chk_frame(16'h0000);
    wait_fv(1'b1);
    trigger_i <= 1'b0;
    wait_fv(1'b0);
    repeat (8) @(posedge clk_sys_i);
    chk_frame(16'h0001);
    hi = 0;
    repeat (16000) begin
      @(posedge clk_sys_i);
      if (flash_o !== 1'b0) hi++;
    end
    chk("flash after trigger low", 16'h0000, 16'(hi));
    bus(1'b0, 8'h1d, 16'h0000);
    chk("frame count", 16'h0002, q);
    // Video mode: trigger held until the stream bit is set, then released.
    bus(1'b1, 8'h14, 16'h0002);
    trigger_i <= 1'b1;
    bus(1'b1, 8'h0d, 16'h0004);
    trigger_i <= 1'b0;
    wait_fv(1'b1);
    wait_fv(1'b0);
    repeat (8) @(posedge clk_sys_i);
    chk_frame(16'h0002);
    wait_fv(1'b1);
    bus(1'b1, 8'h0d, 16'h0000);
    wait_fv(1'b0);
    repeat (8) @(posedge clk_sys_i);
    chk_frame(16'h0003);
    hi = 0;
    repeat (7000) begin
      @(posedge clk_sys_i);
      if (flash_o !== 1'b0) hi++;
    end
    chk("flash after stream off", 16'h0000, 16'(hi));
    close_out();
  end
endmodule
